// file: logic/addr_mode_defines.vh
// Opcode, mode and timing constants for the addressing mode decoder.
// Assumes inclusion by bare name from the decoder source.
`ifndef ADDR_MODE_DEFINES_VH
`define ADDR_MODE_DEFINES_VH

// ------------------------------------------------------------
// Opcodes
// ------------------------------------------------------------
`define OPC_SHIFT_LEFT_ACC 8'h0A
`define OPC_SHIFT_RIGHT_ACC 8'h4A
`define OPC_ROTATE_RIGHT_ACC 8'h6A
`define OPC_LOAD_ACC_IMM 8'hA9
`define OPC_COMPARE_ACC_IMM 8'hC9
`define OPC_SUBTRACT_IMM 8'hE9
`define OPC_INC_MEM_ABS 8'hEE
`define OPC_LOAD_X_ABS 8'hAE
`define OPC_CALL_SUB 8'h20
`define OPC_LOAD_ACC_ZP 8'hA5
`define OPC_OR_ACC_ZP 8'h05
`define OPC_ROTATE_RIGHT_ZP 8'h66
`define OPC_DEC_X 8'hCA
`define OPC_INC_Y 8'hC8
`define OPC_RETURN_SUB 8'h60
`define OPC_BRANCH_ZERO 8'hF0
`define OPC_BRANCH_NONZERO 8'hD0
`define OPC_BRANCH_CARRY_CLR 8'h90

// ------------------------------------------------------------
// Operand kinds
// ------------------------------------------------------------
`define MODE_UNKNOWN 3'h0
`define MODE_ACCUM 3'h1
`define MODE_IMMED 3'h2
`define MODE_ABS 3'h3
`define MODE_ZPAGE 3'h4
`define MODE_IMPLIED 3'h5
`define MODE_RELATIVE 3'h6

// ------------------------------------------------------------
// Lengths and execution cycles
// ------------------------------------------------------------
`define LEN_ONE 2'h1
`define LEN_TWO 2'h2
`define LEN_THREE 2'h3
`define CYC_IMPLIED 3'h2
`define CYC_IMMED 3'h2
`define CYC_ZPAGE 3'h3
`define CYC_ZPAGE_RMW 3'h5
`define CYC_ABS 3'h4
`define CYC_ABS_RMW 3'h6
`define CYC_CALL 3'h6
`define CYC_BRANCH 3'h2
`define CYC_BRANCH_TAKEN 3'h3
`define ZERO_PAGE_HIGH 8'h00

`endif

// file: logic/addressing_mode_decoder.v
// Addressing mode decoder: opcode to length, operand kind, address
// and next program counter, registered one cycle after the request.
// Assumes the memory bus presents one whole instruction (opcode plus
// up to two operand bytes) with a valid strobe, synchronous to clk_i,
// and that the reset pin may fall at any time.
`timescale 1ns/1ps
`default_nettype none
`include "addr_mode_defines.vh"

module addressing_mode_decoder (
  input wire clk_i,              // 200 MHz core clock
  input wire rstn_i,             // Async reset, active low
  input wire instr_valid_i,      // Instruction bytes present
  input wire [7:0] opcode_i,     // Opcode byte
  input wire [7:0] operand_lo_i, // First operand byte
  input wire [7:0] operand_hi_i, // Second operand byte
  input wire [15:0] pc_i,        // Address of the opcode
  input wire zero_flag_i,        // Status zero flag
  input wire carry_flag_i,       // Status carry flag
  output reg dec_valid_o,        // Decode results valid, one cycle
  output reg [1:0] length_o,     // Instruction length in bytes
  output reg [2:0] mode_o,       // Operand kind
  output reg [2:0] exec_cycles_o, // Execution cycles
  output reg [15:0] eff_addr_o,  // Effective address
  output reg [7:0] imm_data_o,   // Immediate data byte
  output reg [15:0] next_pc_o,   // Next program counter
  output reg [7:0] next_pc_page_o, // Page of next program counter
  output reg [7:0] next_pc_offs_o, // Offset within that page
  output reg branch_taken_o,     // Conditional branch taken
  output reg [15:0] return_addr_o, // Saved return address
  output reg illegal_o           // Opcode not decoded here
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  // Reset falls at once and rises two edges after the pin
  reg rst_meta_reg;
  reg rst_sync_reg;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // Opcode table
  // ------------------------------------------------------------
  reg [2:0] mode_next;
  reg [1:0] len_next;
  reg [2:0] cyc_next;
  reg cond_next;
  always @* begin
    mode_next = `MODE_UNKNOWN;
    len_next = `LEN_ONE;
    cyc_next = `CYC_IMPLIED;
    cond_next = 1'b0;
    case (opcode_i)
      `OPC_SHIFT_LEFT_ACC, `OPC_SHIFT_RIGHT_ACC,
      `OPC_ROTATE_RIGHT_ACC: begin
        mode_next = `MODE_ACCUM;
        len_next = `LEN_ONE;
        cyc_next = `CYC_IMPLIED;
      end
      `OPC_LOAD_ACC_IMM, `OPC_COMPARE_ACC_IMM, `OPC_SUBTRACT_IMM: begin
        mode_next = `MODE_IMMED;
        len_next = `LEN_TWO;
        cyc_next = `CYC_IMMED;
      end
      `OPC_INC_MEM_ABS: begin
        mode_next = `MODE_ABS;
        len_next = `LEN_THREE;
        cyc_next = `CYC_ABS_RMW;
      end
      `OPC_LOAD_X_ABS: begin
        mode_next = `MODE_ABS;
        len_next = `LEN_THREE;
        cyc_next = `CYC_ABS;
      end
      `OPC_CALL_SUB: begin
        mode_next = `MODE_ABS;
        len_next = `LEN_THREE;
        cyc_next = `CYC_CALL;
      end
      // zero-page forms; fewer cycles than absolute
      `OPC_LOAD_ACC_ZP, `OPC_OR_ACC_ZP: begin
        mode_next = `MODE_ZPAGE;
        len_next = `LEN_TWO;
        cyc_next = `CYC_ZPAGE;
      end
      `OPC_ROTATE_RIGHT_ZP: begin
        mode_next = `MODE_ZPAGE;
        len_next = `LEN_TWO;
        cyc_next = `CYC_ZPAGE_RMW;
      end
      `OPC_DEC_X, `OPC_INC_Y, `OPC_RETURN_SUB: begin
        mode_next = `MODE_IMPLIED;
        len_next = `LEN_ONE;
        cyc_next = `CYC_IMPLIED;
      end
      `OPC_BRANCH_ZERO: begin
        mode_next = `MODE_RELATIVE;
        len_next = `LEN_TWO;
        cond_next = zero_flag_i;
      end
      `OPC_BRANCH_NONZERO: begin
        mode_next = `MODE_RELATIVE;
        len_next = `LEN_TWO;
        cond_next = ~zero_flag_i;
      end
      `OPC_BRANCH_CARRY_CLR: begin
        mode_next = `MODE_RELATIVE;
        len_next = `LEN_TWO;
        cond_next = ~carry_flag_i;
      end
      default: begin
        mode_next = `MODE_UNKNOWN;
        len_next = `LEN_ONE;
        cyc_next = `CYC_IMPLIED;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Address arithmetic
  // ------------------------------------------------------------
  // Sequential address after the instruction
  wire [15:0] seq_pc;
  assign seq_pc = pc_i + {14'h0000, len_next};

  // bit 7 set means backward displacement
  wire [15:0] offs_ext;
  assign offs_ext = {{8{operand_lo_i[7]}}, operand_lo_i};

  // signed add; base is byte after operand
  wire [15:0] branch_target;
  assign branch_target = seq_pc + offs_ext;

  wire [15:0] abs_addr;
  assign abs_addr = {operand_hi_i, operand_lo_i};

  // ------------------------------------------------------------
  // Instruction class flags
  // ------------------------------------------------------------
  wire is_call;
  wire is_return;
  wire is_branch;
  wire is_immed;
  wire is_unknown;
  wire take_branch;
  assign is_call = (opcode_i == `OPC_CALL_SUB);
  assign is_return = (opcode_i == `OPC_RETURN_SUB);
  assign is_branch = (mode_next == `MODE_RELATIVE);
  assign is_immed = (mode_next == `MODE_IMMED);
  assign is_unknown = (mode_next == `MODE_UNKNOWN);
  assign take_branch = is_branch & cond_next;

  // ------------------------------------------------------------
  // Target selection
  // ------------------------------------------------------------
  reg [15:0] ea_next;
  reg [15:0] pc_next;
  always @* begin
    ea_next = 16'h0000;
    pc_next = seq_pc;
    case (mode_next)
      `MODE_ABS: ea_next = abs_addr;
      `MODE_ZPAGE: ea_next = {`ZERO_PAGE_HIGH, operand_lo_i};
      `MODE_RELATIVE: ea_next = branch_target;
      default: ea_next = 16'h0000;
    endcase
    // call jumps to its absolute target
    if (is_call) begin
      pc_next = abs_addr;
    end else if (is_return) begin
      pc_next = return_addr_o;
    end else if (take_branch) begin
      pc_next = branch_target;
    end
  end

  // high byte page, low byte offset
  wire [7:0] pc_page_next;
  wire [7:0] pc_offs_next;
  assign pc_page_next = pc_next[15:8];
  assign pc_offs_next = pc_next[7:0];

  // ------------------------------------------------------------
  // Execution cycles
  // ------------------------------------------------------------
  // Taken branches pay one extra cycle for the redirect
  reg [2:0] exec_next;
  always @* begin
    exec_next = cyc_next;
    if (is_branch) begin
      if (cond_next) begin
        exec_next = `CYC_BRANCH_TAKEN;
      end else begin
        exec_next = `CYC_BRANCH;
      end
    end
  end

  wire [7:0] imm_next;
  assign imm_next = is_immed ? operand_lo_i : 8'h00;

  // ------------------------------------------------------------
  // Decode field registers
  // ------------------------------------------------------------
  // Fields hold until the next valid instruction
  always @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      length_o <= 2'h0;
      mode_o <= `MODE_UNKNOWN;
      exec_cycles_o <= 3'h0;
      imm_data_o <= 8'h00;
    end else if (instr_valid_i) begin
      length_o <= len_next;
      mode_o <= mode_next;
      exec_cycles_o <= exec_next;
      imm_data_o <= imm_next;
    end
  end

  // ------------------------------------------------------------
  // Address and program counter registers
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      eff_addr_o <= 16'h0000;
      next_pc_o <= 16'h0000;
      next_pc_page_o <= 8'h00;
      next_pc_offs_o <= 8'h00;
    end else if (instr_valid_i) begin
      eff_addr_o <= ea_next;
      next_pc_o <= pc_next;
      next_pc_page_o <= pc_page_next;
      next_pc_offs_o <= pc_offs_next;
    end
  end

  // ------------------------------------------------------------
  // One-cycle status pulses
  // ------------------------------------------------------------
  // Idle cycles clear them so no flag repeats without a request
  always @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      dec_valid_o <= 1'b0;
      branch_taken_o <= 1'b0;
      illegal_o <= 1'b0;
    end else begin
      dec_valid_o <= instr_valid_i;
      branch_taken_o <= instr_valid_i & take_branch;
      illegal_o <= instr_valid_i & is_unknown;
    end
  end

  // ------------------------------------------------------------
  // Return address
  // ------------------------------------------------------------
  // Single level only: a nested call overwrites the saved address
  always @(posedge clk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      return_addr_o <= 16'h0000;
    end else if (instr_valid_i && is_call) begin
      return_addr_o <= seq_pc;
    end
  end

endmodule // addressing_mode_decoder
`default_nettype wire

// file: testbench/addr_mode_asserts.sv
// Checker of decode results and answer timing at the decoder ports.
// Assumes the defines header is on the include path.
`timescale 1ns/1ps
`default_nettype none
module addr_mode_checker (
  input wire logic clk_i, // clock
  input wire logic rstn_i, // reset, low
  input wire logic instr_valid_i, // request
  input wire logic [7:0] opcode_i, // opcode
  input wire logic [7:0] operand_lo_i, // byte 2
  input wire logic [7:0] operand_hi_i, // byte 3
  input wire logic [15:0] pc_i, // opcode address
  input wire logic zero_flag_i, // zero flag
  input wire logic carry_flag_i, // carry flag
  input wire logic dec_valid_o, // answer
  input wire logic [1:0] length_o, // length
  input wire logic [2:0] mode_o, // kind
  input wire logic [2:0] exec_cycles_o, // cycles
  input wire logic [15:0] eff_addr_o, // address
  input wire logic [15:0] next_pc_o, // next pc
  input wire logic branch_taken_o, // taken
  input wire logic [15:0] return_addr_o // saved pc
);
  // ----------------------------------------
  // Branch condition and target
  // ----------------------------------------
  logic v;
  logic go;
  logic [7:0] op;
  logic [7:0] lo;
  logic [15:0] tgt;
  assign v = instr_valid_i;
  assign op = opcode_i;
  assign lo = operand_lo_i;
  assign go = op == 8'hF0 ? zero_flag_i : op == 8'hD0 ? !zero_flag_i
    : !carry_flag_i;
  assign tgt = pc_i + 16'h0002 + {{8{lo[7]}}, lo};
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_answer_next_cycle: assert property (dec_valid_o == $past(v))
    else $error("answer not one cycle after request");
  a_accum_one_byte: assert property (v && op inside {8'h0A,
    8'h4A, 8'h6A} |=> mode_o == 3'h1 && length_o == 2'h1)
    else $error("accumulator decode wrong");
  a_immed_two_bytes: assert property (v && op inside {8'hA9,
    8'hC9, 8'hE9} |=> mode_o == 3'h2 && length_o == 2'h2)
    else $error("immediate decode wrong");
  a_abs_full_addr: assert property (v && op inside {8'hEE, 8'hAE}
    |=> length_o == 2'h3 && eff_addr_o == {$past(operand_hi_i), $past(lo)})
    else $error("absolute address wrong");
  a_zpage_high_zero: assert property (v && op inside {8'hA5,
    8'h05, 8'h66} |=> mode_o == 3'h4 && eff_addr_o == {8'h00, $past(lo)})
    else $error("zero page address wrong");
  a_zpage_faster: assert property (v && op inside {8'hA5, 8'hAE}
    |=> exec_cycles_o == ($past(op) == 8'hAE ? 3'h4 : 3'h3))
    else $error("zero page not faster");
  a_implied_one_byte: assert property (v && op inside {8'hCA,
    8'hC8, 8'h60} |=> mode_o == 3'h5 && length_o == 2'h1)
    else $error("implied decode wrong");
  a_call_saves_pc: assert property (v && op == 8'h20 |=>
    return_addr_o == $past(pc_i) + 16'h0003)
    else $error("return address wrong");
  a_branch_taken: assert property (v && op inside {8'hF0, 8'hD0,
    8'h90} |=> branch_taken_o == $past(go) ##0 length_o == 2'h2)
    else $error("branch condition wrong");
  a_branch_target: assert property (v && op inside {8'hF0,
    8'hD0, 8'h90} |=> next_pc_o == ($past(go) ? $past(tgt)
    : $past(pc_i) + 16'h0002))
    else $error("branch next pc wrong");
  c_taken: cover property (branch_taken_o);
  c_call: cover property (v && op == 8'h20);
  c_return: cover property (v && op == 8'h60);
endmodule // addr_mode_checker
bind addressing_mode_decoder addr_mode_checker CHK (.clk_i(clk_i),
  .rstn_i(rstn_i), .instr_valid_i(instr_valid_i), .opcode_i(opcode_i),
  .operand_lo_i(operand_lo_i), .operand_hi_i(operand_hi_i), .pc_i(pc_i),
  .zero_flag_i(zero_flag_i), .carry_flag_i(carry_flag_i),
  .dec_valid_o(dec_valid_o), .length_o(length_o), .mode_o(mode_o),
  .exec_cycles_o(exec_cycles_o), .eff_addr_o(eff_addr_o),
  .next_pc_o(next_pc_o), .branch_taken_o(branch_taken_o),
  .return_addr_o(return_addr_o));
`default_nettype wire

// file: testbench/instr_memory.sv
// Memory model serving the three bytes at a fetch address.
// Assumes the bench loads it with put before each fetch.
`timescale 1ns/1ps
`default_nettype none
module instr_memory (
  input wire logic clk_i, // clock
  input wire logic en_i, // fetch on
  input wire logic [15:0] addr_i, // opcode address
  output logic [7:0] op_o, // opcode
  output logic [7:0] lo_o, // byte 2
  output logic [7:0] hi_o // byte 3
);
  logic [7:0] mem [0:65535];
  logic [7:0] junk_reg = 8'h5A;
  // Idle bytes churn so stale data never looks valid
  always @(posedge clk_i) junk_reg <= ~junk_reg + 8'h01;
  assign op_o = en_i ? mem[addr_i] : junk_reg;
  assign lo_o = en_i ? mem[addr_i + 16'h0001] : ~junk_reg;
  assign hi_o = en_i ? mem[addr_i + 16'h0002] : junk_reg;
  task automatic put(input logic [15:0] a, input logic [7:0] b0, b1, b2);
    mem[a] = b0;
    mem[a + 16'h0001] = b1;
    mem[a + 16'h0002] = b2;
  endtask
endmodule // instr_memory
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the addressing mode decoder.
// Assumes the design and the memory model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic vld = 1'b0;
  logic zf = 1'b0;
  logic cf = 1'b0;
  logic [15:0] pc = 16'h0000;
  logic [7:0] op, lo, hi, pg, ofs, imm;
  logic dv, bt, ill;
  logic [1:0] len;
  logic [2:0] md, cyc;
  logic [15:0] ea, npc, ra;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  instr_memory MEM (.clk_i(clk_i), .en_i(vld), .addr_i(pc), .op_o(op),
    .lo_o(lo), .hi_o(hi));
  addressing_mode_decoder DUT (.clk_i(clk_i), .rstn_i(rstn_i),
    .instr_valid_i(vld), .opcode_i(op), .operand_lo_i(lo),
    .operand_hi_i(hi), .pc_i(pc), .zero_flag_i(zf), .carry_flag_i(cf),
    .dec_valid_o(dv), .length_o(len), .mode_o(md), .exec_cycles_o(cyc),
    .eff_addr_o(ea), .imm_data_o(imm), .next_pc_o(npc), .next_pc_page_o(pg),
    .next_pc_offs_o(ofs), .branch_taken_o(bt), .return_addr_o(ra),
    .illegal_o(ill));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic chk(input string n, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask
  task automatic run(input logic [15:0] a, input logic z, c);
    @(posedge clk_i);
    #1 vld = 1'b1;
    pc = a;
    zf = z;
    cf = c;
    @(posedge clk_i);
    #1 vld = 1'b0;
    chk("dec_valid", 16'h0001, 16'(dv));
  endtask
  task automatic t_modes;
    logic [7:0] ops [14] = '{8'h0A, 8'h4A, 8'h6A, 8'hA9, 8'hC9, 8'hE9,
      8'hEE, 8'hAE, 8'hA5, 8'h05, 8'h66, 8'hCA, 8'hC8, 8'h02};
    logic [2:0] cx [14] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h6,
      3'h4, 3'h3, 3'h3, 3'h5, 3'h2, 3'h2, 3'h2};
    logic [2:0] m;
    logic [1:0] n;
    logic [15:0] a;
    logic [15:0] e;
    for (int i = 0; i < 14; i++) begin
      m = i < 3 ? 3'h1 : i < 6 ? 3'h2 : i < 8 ? 3'h3 : i < 11 ? 3'h4
        : i < 13 ? 3'h5 : 3'h0;
      n = m == 3'h3 ? 2'h3 : m == 3'h2 || m == 3'h4 ? 2'h2 : 2'h1;
      a = 16'h20F0 + 16'(i);
      e = a + 16'(n);
      MEM.put(a, ops[i], 8'h34, 8'h12);
      run(a, 1'b0, 1'b0);
      chk("mode", 16'(m), 16'(md));
      chk("length", 16'(n), 16'(len));
      chk("next_pc", e, npc);
      chk("page", e, {pg, ofs});
      chk("eff_addr", m == 3'h3 ? 16'h1234 : m == 3'h4 ? 16'h0034
        : 16'h0000, ea);
      chk("imm_data", m == 3'h2 ? 16'h0034 : 16'h0000, 16'(imm));
      chk("cycles", 16'(cx[i]), 16'(cyc));
      chk("illegal", 16'(i == 13), 16'(ill));
    end
  endtask
  task automatic t_branch;
    logic [7:0] ops [6] = '{8'hF0, 8'hF0, 8'hD0, 8'hD0, 8'h90, 8'h90};
    logic [7:0] offs [6] = '{8'hFC, 8'hFC, 8'h7F, 8'h7F, 8'h80, 8'h80};
    logic [15:0] a;
    logic t;
    for (int i = 0; i < 6; i++) begin
      a = i < 2 ? 16'h1806 : 16'h10FE;
      t = i[0] ^ (i < 2);
      MEM.put(a, ops[i], offs[i], 8'h00);
      run(a, i < 2 ? t : !t, !t);
      chk("taken", 16'(t), 16'(bt));
      chk("target", a + 16'h0002 + (t ? {{8{offs[i][7]}}, offs[i]}
        : 16'h0000), npc);
      chk("mode", 16'h0006, 16'(md));
      chk("branch_ea", a + 16'h0002 + {{8{offs[i][7]}}, offs[i]},
        ea);
      chk("length", 16'h0002, 16'(len));
      chk("cycles", t ? 16'h0003 : 16'h0002, 16'(cyc));
    end
  endtask
  task automatic t_call;
    MEM.put(16'h1000, 8'h20, 8'hC3, 8'hFF);
    run(16'h1000, 1'b0, 1'b0);
    chk("call_pc", 16'hFFC3, npc);
    chk("ret_addr", 16'h1003, ra);
    MEM.put(16'hFFC3, 8'h60, 8'h00, 8'h00);
    run(16'hFFC3, 1'b0, 1'b0);
    chk("ret_pc", 16'h1003, npc);
  endtask
  task automatic end_sim;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    repeat (2) @(posedge clk_i);
    t_modes();
    t_branch();
    t_call();
    #1 rstn_i = 1'b0;
    #1 chk("reset_ret", 16'h0000, ra);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
